// >>> core/bbx_core.sv
// execution core for branches, bit ops, shifts, flag ops and data transfers
// Function
// (RULE1) carry branches: same/higher on C=0, lower on C=1
// (RULE2) signed branches test N xor V; minus/plus test N
// (RULE3) half-carry branches jump on H set/clear
// (RULE4) T-flag branches jump on T set/clear
// (RULE5) overflow branches on V; branches keep flags
// (RULE6) interrupt-state branches on I; 1 or 2 cycles
// (RULE7) io bit set/clear in 2 cycles, flags kept
// (RULE8) rotates go through carry, update Z C N V
// (RULE9) shifts: arith keeps bit7, logical insert zero
// (RULE10) one-cycle set/clear of any status flag
// (RULE11) bit store to T, bit load from T
// (RULE12) global irq on/off in one cycle
// (RULE13) register copy, pair copy, constant load, one cycle
// (RULE14) pointer load 2 cycles, optional post-increment
// (RULE15) pre-decrement pointer before access, 2 cycles
// (RULE16) displacement only via Y or Z, pointer kept
// (RULE17) direct load/store by address k, 2 cycles
// (RULE18) pointer store 2 cycles, optional post-increment
// (RULE19) code byte load via Z in 3 cycles
// (RULE20) no-flag instructions leave all flags unchanged
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module bbx_core import bbx_pkg::*; (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // program memory, asynchronous read
  output logic      [15:0] o_pm_addr,
  input  wire logic [31:0] i_pm_data,
  // data memory, asynchronous read
  output logic      [15:0] o_dm_addr,
  output logic             o_dm_re,
  output logic             o_dm_we,
  output logic      [7:0]  o_dm_wdata,
  input  wire logic [7:0]  i_dm_rdata,
  // io space bit write strobe
  output logic      [5:0]  o_io_addr,
  output logic      [7:0]  o_io_bit_mask,
  output logic             o_io_bit_val,
  output logic             o_io_bit_we
);

  logic [7:0]  regs [0:31];   // working registers
  logic [7:0]  flags;         // status flags register
  logic [15:0] pc;            // word program counter
  logic [31:0] ir;            // instruction held past first cycle
  logic [7:0]  lpm_byte;      // code byte caught in second cycle
  logic        run;           // software run enable
  logic [4:0]  rsel;          // register peek index
  bbx_state_t  state;
  bbx_state_t  next_state;
  logic [7:0]  next_flags;

  // instruction fields; first cycle decodes straight from memory
  wire         e1  = (state == CS_E1);
  wire         e2  = (state == CS_E2);
  wire [31:0]  cur = e1 ? i_pm_data : ir;
  bbx_op_t     op;
  assign op = bbx_op_t'(cur[31:26]);
  wire [4:0]   rd  = cur[25:21];
  wire [4:0]   rr  = cur[20:16];
  wire [15:0]  imm = cur[15:0];
  wire [7:0]   rd_val = regs[rd];
  wire [7:0]   rr_val = regs[rr];
  wire [2:0]   bidx   = imm[2:0];
  wire [7:0]   bmask  = 8'h01 << bidx;

  // the opcode space is dense up to OP_LPM; any opcode above it
  // falls through every decoder as a one-cycle no-op
  // op classes
  wire is_br    = op inside {[OP_BR_SH:OP_BR_ID]};
  wire is_sh    = op inside {[OP_LSL:OP_ASR]};
  wire is_io    = (op == OP_IO_SET) || (op == OP_IO_CLR);
  wire is_load  = op inside {OP_LD, OP_LDD, OP_LDS};
  wire is_store = op inside {OP_ST, OP_STD, OP_STS};
  wire is_disp  = (op == OP_LDD) || (op == OP_STD);
  wire is_ldst  = (op == OP_LD) || (op == OP_ST);
  wire is_lpm   = (op == OP_LPM);

  // branch condition; no branch touches the flags
  logic br_hit;
  always_comb begin
    case (op)
      OP_BR_SH: br_hit = ~flags[FL_C];                 // RULE1
      OP_BR_LO: br_hit = flags[FL_C];                  // RULE1
      OP_BR_MI: br_hit = flags[FL_N];                  // RULE2
      OP_BR_PL: br_hit = ~flags[FL_N];                 // RULE2
      OP_BR_GE: br_hit = ~(flags[FL_N] ^ flags[FL_V]); // RULE2
      OP_BR_LT: br_hit = flags[FL_N] ^ flags[FL_V];    // RULE2
      OP_BR_HS: br_hit = flags[FL_H];                  // RULE3
      OP_BR_HC: br_hit = ~flags[FL_H];                 // RULE3
      OP_BR_TS: br_hit = flags[FL_T];                  // RULE4
      OP_BR_TC: br_hit = ~flags[FL_T];                 // RULE4
      OP_BR_VS: br_hit = flags[FL_V];                  // RULE5
      OP_BR_VC: br_hit = ~flags[FL_V];                 // RULE5
      OP_BR_IE: br_hit = flags[FL_I];                  // RULE6
      OP_BR_ID: br_hit = ~flags[FL_I];                 // RULE6
      default:  br_hit = 1'b0;
    endcase
  end
  // the offset wraps modulo 64k words, like the pc itself
  // relative target pc+k+1, k signed 7 bits
  wire [15:0] br_target = pc + {{9{imm[6]}}, imm[6:0]} + 16'h0001;

  // one shared shifter; its carry out feeds both C and V
  // shifter and rotator
  logic [7:0] sh_res;
  logic       sh_c;
  always_comb begin
    case (op)
      OP_LSL:  {sh_c, sh_res} = {rd_val, 1'b0};           // RULE9
      OP_LSR:  {sh_res, sh_c} = {1'b0, rd_val};           // RULE9
      OP_ROL:  {sh_c, sh_res} = {rd_val, flags[FL_C]};    // RULE8
      OP_ROR:  {sh_res, sh_c} = {flags[FL_C], rd_val};    // RULE8
      OP_ASR:  {sh_res, sh_c} = {rd_val[7], rd_val};      // RULE9
      default: {sh_res, sh_c} = 9'h000;
    endcase
  end
  wire [7:0] bld_res = (rd_val & ~bmask) | (flags[FL_T] ? bmask : 8'h00); // RULE11

  // pointer index 3 aliases to Z so no encoding is left undefined
  // pointer select; displacement form only reaches Y or Z
  wire [1:0]  psel  = imm[1:0];
  wire [1:0]  pmode = imm[3:2];
  wire [4:0]  plo   = is_disp ? (imm[6] ? PTR_Z : PTR_Y) :      // RULE16
                      (psel == 2'h0) ? PTR_X : (psel == 2'h1) ? PTR_Y : PTR_Z;
  wire [15:0] pval  = {regs[plo + 5'd1], regs[plo]};
  wire [15:0] zval  = {regs[PTR_Z + 5'd1], regs[PTR_Z]};
  wire        predec = is_ldst && (pmode == PM_PREDEC);
  // effective data address
  wire [15:0] ea = is_disp ? pval + {10'h000, imm[5:0]} :       // RULE16
                   (op == OP_LDS || op == OP_STS) ? imm :       // RULE17
                   predec ? pval - 16'h0001 : pval;              // RULE15

  // a taken branch spends its second cycle idle; pc takes the target at the end of it
  // cycles per instruction and last-cycle marker
  wire [1:0] ncyc = is_br ? (br_hit ? 2'd2 : 2'd1) :            // RULE1
                    (is_io || is_load || is_store) ? 2'd2 :      // RULE7
                    is_lpm ? 2'd3 : 2'd1;                        // RULE19
  wire last = (e1 && ncyc == 2'd1) || (e2 && ncyc == 2'd2) || (state == CS_E3);

  // pointer write-back on the last cycle
  wire        ptr_we   = last && ((is_ldst && pmode != PM_PLAIN) || (is_lpm && imm[1]));
  wire [4:0]  ptr_idx  = is_lpm ? PTR_Z : plo;
  wire [15:0] ptr_base = is_lpm ? zval : pval;
  wire [15:0] ptr_next = (is_lpm || pmode == PM_POSTINC) ? ptr_base + 16'h0001 // RULE14
                                                          : ptr_base - 16'h0001; // RULE15

  // the second cycle borrows the fetch port, so no fetch happens then
  // code byte: Z selects word Z[15:2] and byte lane Z[1:0]
  wire [4:0] lpm_dst = imm[0] ? 5'd0 : rd;                     // RULE19
  assign o_pm_addr = (e2 && is_lpm) ? {2'b00, zval[15:2]} : pc;
  wire [7:0] pm_byte = i_pm_data[{zval[1:0], 3'b000} +: 8];

  // loads write in the second cycle, when the data memory answers
  // single-byte register write port
  logic       rf_we;
  logic [4:0] rf_wa;
  logic [7:0] rf_wd;
  always_comb begin
    rf_we = 1'b0;
    rf_wa = rd;
    rf_wd = 8'h00;
    case (op)
      OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR: begin
        rf_we = e1;
        rf_wd = sh_res;
      end
      OP_BLD: begin
        rf_we = e1;
        rf_wd = bld_res;                                      // RULE11
      end
      OP_MOV: begin
        rf_we = e1;
        rf_wd = rr_val;                                       // RULE13
      end
      OP_LDI: begin
        rf_we = e1;
        rf_wd = imm[7:0];                                     // RULE13
      end
      OP_LD, OP_LDD, OP_LDS: begin
        rf_we = e2;
        rf_wd = i_dm_rdata;                                   // RULE14
      end
      OP_LPM: begin
        rf_we = (state == CS_E3);
        rf_wa = lpm_dst;
        rf_wd = lpm_byte;                                     // RULE19
      end
      default: rf_we = 1'b0;
    endcase
  end
  wire       mw_we = e1 && (op == OP_REG_PAIR_COPY);
  wire [4:0] mw_d  = {rd[4:1], 1'b0};
  wire [4:0] mw_s  = {rr[4:1], 1'b0};

  // S is never recomputed here; only indexed set/clear touches it
  // flag updates; any op not listed keeps every flag
  always_comb begin
    next_flags = flags;                                       // RULE20
    if (e1) begin
      case (op)
        OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR: begin
          next_flags[FL_C] = sh_c;                            // RULE8
          next_flags[FL_Z] = (sh_res == 8'h00);
          next_flags[FL_N] = sh_res[7];
          next_flags[FL_V] = sh_res[7] ^ sh_c;                // RULE9
        end
        OP_FLAG_SET: next_flags[bidx] = 1'b1;                 // RULE10
        OP_FLAG_CLR: next_flags[bidx] = 1'b0;                 // RULE10
        OP_BST:      next_flags[FL_T] = rd_val[bidx];         // RULE11
        OP_IRQ_ON:   next_flags[FL_I] = 1'b1;                 // RULE12
        OP_IRQ_OFF:  next_flags[FL_I] = 1'b0;                 // RULE12
        default:     next_flags = flags;
      endcase
    end
  end

  // run is looked at only at instruction ends, so no op is cut short
  // sequencer; stopping only takes effect between instructions
  always_comb begin
    case (state)
      CS_IDLE: next_state = run ? CS_E1 : CS_IDLE;
      CS_E1:   next_state = (ncyc != 2'd1) ? CS_E2 : (run ? CS_E1 : CS_IDLE);
      CS_E2:   next_state = (ncyc == 2'd3) ? CS_E3 : (run ? CS_E1 : CS_IDLE);
      CS_E3:   next_state = run ? CS_E1 : CS_IDLE;
      default: next_state = CS_IDLE;
    endcase
  end
  wire [15:0] next_pc = !last ? pc : (is_br && br_hit) ? br_target : pc + 16'h0001; // RULE1

  // ir keeps the word for later cycles while the fetch port moves on
  // state, pc, flags, instruction latch
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state    <= CS_IDLE;
      pc       <= RST_PC;
      flags    <= RST_FLAGS;
      ir       <= 32'h00000000;
      lpm_byte <= 8'h00;
    end else begin
      state    <= next_state;
      pc       <= next_pc;
      flags    <= next_flags;
      ir       <= e1 ? i_pm_data : ir;
      lpm_byte <= (e2 && is_lpm) ? pm_byte : lpm_byte;
    end
  end

  // reset clears every working register so reads after reset are known
  // register file; pointer write comes last so it wins a clash
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 32; i++) regs[i] <= RST_REG;
    end else begin
      if (rf_we) regs[rf_wa] <= rf_wd;
      if (mw_we) begin
        regs[mw_d]        <= regs[mw_s];                      // RULE13
        regs[mw_d + 5'd1] <= regs[mw_s + 5'd1];
      end
      if (ptr_we) begin
        regs[ptr_idx]        <= ptr_next[7:0];
        regs[ptr_idx + 5'd1] <= ptr_next[15:8];
      end
    end
  end

  // address and data stay put so the memory sees them settled all cycle
  // data memory request held for the second cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dm_addr  <= 16'h0000;
      o_dm_re    <= 1'b0;
      o_dm_we    <= 1'b0;
      o_dm_wdata <= 8'h00;
    end else begin
      o_dm_addr  <= (e1 && (is_load || is_store)) ? ea : o_dm_addr;   // RULE17
      o_dm_re    <= e1 && is_load;                                    // RULE14
      o_dm_we    <= e1 && is_store;                                   // RULE18
      o_dm_wdata <= (e1 && is_store) ? rr_val : o_dm_wdata;
    end
  end

  // a one-cycle strobe keeps the io side from seeing a repeated write
  // io bit strobe in the second cycle; the io space merges the bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_io_addr     <= 6'h00;
      o_io_bit_mask <= 8'h00;
      o_io_bit_val  <= 1'b0;
      o_io_bit_we   <= 1'b0;
    end else begin
      o_io_addr     <= (e1 && is_io) ? imm[5:0] : o_io_addr;
      o_io_bit_mask <= (e1 && is_io) ? (8'h01 << imm[8:6]) : o_io_bit_mask;
      o_io_bit_val  <= (e1 && is_io) ? (op == OP_IO_SET) : o_io_bit_val; // RULE7
      o_io_bit_we   <= e1 && is_io;
    end
  end

  // ack is registered, so every access costs exactly one wait state
  // wishbone slave: ack one cycle after request, write at ack edge
  wire        wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire        wb_wr  = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0];
  wire [31:0] wb_rmux = (i_wb_adr == ADR_CTRL)  ? {29'h0, state, run} :
                        (i_wb_adr == ADR_FLAGS) ? {24'h0, flags} :
                        (i_wb_adr == ADR_PC)    ? {16'h0, pc} :
                        (i_wb_adr == ADR_RSEL)  ? {27'h0, rsel} :
                        (i_wb_adr == ADR_RDATA) ? {24'h0, regs[rsel]} : 32'h00000000;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      run      <= 1'b0;
      rsel     <= 5'h00;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= (wb_req && !i_wb_we) ? wb_rmux : o_wb_dat;
      run      <= (wb_wr && i_wb_adr == ADR_CTRL) ? i_wb_dat[0] : run;
      rsel     <= (wb_wr && i_wb_adr == ADR_RSEL) ? i_wb_dat[4:0] : rsel;
    end
  end

  // checks
  // branch conditions are judged by the cycles that the branch costs,
  // so a wrong condition shows up as a wrong sequencer step
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_two_cyc;
    e2 ##1 (state == CS_E1 || state == CS_IDLE);
  endsequence
  sequence s_three_cyc;
    e2 ##1 (state == CS_E3) ##1 (state == CS_E1 || state == CS_IDLE);
  endsequence

  a_branch_taken: assert property (e1 && is_br && br_hit |=> e2 ##1 pc == $past(br_target, 2)) // RULE1
    else $error("taken branch missed target or time");
  a_branch_skip: assert property (e1 && is_br && !br_hit |=> !e2 && pc == $past(pc) + 16'h0001) // RULE3
    else $error("untaken branch took wrong path");
  a_signed_cond: assert property (e1 && op == OP_BR_LT |=> e2 == ($past(flags[FL_N]) ^ $past(flags[FL_V]))) // RULE2
    else $error("signed branch condition wrong");
  a_irq_branch: assert property (e1 && op == OP_BR_ID |=> e2 == !$past(flags[FL_I])) // RULE6
    else $error("irq branch condition wrong");
  a_branch_flags: assert property (e1 && is_br |=> flags == $past(flags)) // RULE5
    else $error("branch changed flags");
  a_io_bit_op: assert property (e1 && is_io |=> o_io_bit_we && o_io_bit_val == ($past(op) == OP_IO_SET)
                                ##1 !o_io_bit_we) // RULE7
    else $error("io bit strobe wrong");
  a_rotate_carry: assert property (e1 && op == OP_ROL |=>
                                   flags[FL_C] == $past(rd_val[7]) && regs[$past(rd)][0] == $past(flags[FL_C])) // RULE8
    else $error("rotate through carry wrong");
  a_asr_msb_kept: assert property (e1 && op == OP_ASR |=> regs[$past(rd)][7] == $past(rd_val[7])) // RULE9
    else $error("arith shift lost sign");
  a_tflag_store: assert property (e1 && op == OP_BST |=> flags[FL_T] == $past(rd_val[bidx])) // RULE11
    else $error("bit store to T wrong");
  a_irq_on: assert property (e1 && op == OP_IRQ_ON |=> flags[FL_I]) // RULE12
    else $error("irq enable not set");
  a_load_two: assert property (e1 && is_load |=> (o_dm_re && o_dm_addr == $past(ea)) ##0 s_two_cyc) // RULE14
    else $error("load request wrong");
  a_predec_addr: assert property (e1 && is_ldst && predec |=> o_dm_addr == $past(pval) - 16'h0001) // RULE15
    else $error("pre-decrement address wrong");
  a_lpm_three: assert property (e1 && is_lpm |=> s_three_cyc) // RULE19
    else $error("code load not three cycles");
endmodule : bbx_core

// >>> dv/bbx_mem_model.sv
// program memory, data memory and io space that sit behind the execution core
`timescale 1ns/1ps
module bbx_mem_model (
  // clock
  input  wire logic        i_clk,
  // program memory
  input  wire logic [15:0] i_pm_addr,
  output logic      [31:0] o_pm_data,
  // data memory
  input  wire logic [15:0] i_dm_addr,
  input  wire logic        i_dm_re,
  input  wire logic        i_dm_we,
  input  wire logic [7:0]  i_dm_wdata,
  output logic      [7:0]  o_dm_rdata,
  // io bit strobe
  input  wire logic [5:0]  i_io_addr,
  input  wire logic [7:0]  i_io_bit_mask,
  input  wire logic        i_io_bit_val,
  input  wire logic        i_io_bit_we
);
  logic [31:0] pm [64];  // code words, loaded by the bench
  logic [7:0]  dm [256]; // data bytes
  logic [7:0]  io [64];  // io registers
  // unselected reads give inverted data, so a sample outside the strobe shows up
  assign o_pm_data  = (i_pm_addr < 16'h0040) ? pm[i_pm_addr[5:0]] : 32'hffffffff;
  assign o_dm_rdata = i_dm_re ? dm[i_dm_addr[7:0]] : ~dm[i_dm_addr[7:0]];
  // writes land at the end of the strobe cycle
  always @(posedge i_clk) begin
    if (i_dm_we) dm[i_dm_addr[7:0]] <= i_dm_wdata;
    if (i_io_bit_we) io[i_io_addr] <= i_io_bit_val ? (io[i_io_addr] | i_io_bit_mask) :
                                                     (io[i_io_addr] & ~i_io_bit_mask);
  end
  // everything starts cleared
  initial begin
    for (int i = 0; i < 256; i++) begin
      dm[i] = 8'h00;
      if (i < 64) pm[i] = 32'h0;
      if (i < 64) io[i] = 8'h00;
    end
  end
endmodule : bbx_mem_model

// >>> dv/tb.sv
// bench: runs a short program on the core and checks the result over wishbone
`timescale 1ns/1ps
module tb import bbx_pkg::*; ;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h1;
  logic [31:0] rdat, pm_d, q;
  logic        ack, dm_re, dm_we, io_val, io_we, go = 1'b0;
  logic [15:0] pm_a, dm_a;
  logic [7:0]  dm_w, dm_r, io_m;
  logic [5:0]  io_a;
  int          err_count = 0, checks_done = 0, pn = 0, cycn = 0, n;
  int          stamp [64] = '{default: -1}; // first cycle each code address is seen
  // cycle table: from address, to address, cycles
  int tf [32] = '{1, 2, 4, 5, 6, 9, 11, 12, 13, 15, 16, 17, 18, 21, 22, 25, 26, 27, 28, 30, 31, 34,
                  37, 39, 41, 43, 44, 46, 47, 48, 49, 50};
  int tt [32] = '{2, 4, 5, 6, 8, 10, 12, 13, 15, 16, 17, 18, 19, 22, 23, 26, 27, 28, 29, 31, 32, 35,
                  39, 41, 43, 44, 46, 47, 48, 49, 50, 51};
  int tn [32] = '{1, 2, 1, 1, 2, 1, 1, 1, 2, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 1, 1, 3,
                  2, 2, 2, 1, 2, 1, 1, 1, 2, 2};
  // code addresses that a taken branch must skip
  int sk [7] = '{3, 7, 14, 38, 40, 42, 45};
  // register checks: index and final value
  int rn [15] = '{16, 17, 18, 19, 20, 21, 22, 23, 24, 26, 27, 28, 30, 29, 25};
  int rv [15] = '{'h40, 1, 'h5a, 'ha7, 'h3c, 'h40, 'h20, 0, 'h97, 'h20, 0, 'h30, 'h8c, 0, 'h40};
  always #5 clk = ~clk;
  bbx_core i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_pm_addr(pm_a), .i_pm_data(pm_d), .o_dm_addr(dm_a), .o_dm_re(dm_re), .o_dm_we(dm_we),
    .o_dm_wdata(dm_w), .i_dm_rdata(dm_r), .o_io_addr(io_a), .o_io_bit_mask(io_m),
    .o_io_bit_val(io_val), .o_io_bit_we(io_we));
  bbx_mem_model i_mem (.i_clk(clk), .i_pm_addr(pm_a), .o_pm_data(pm_d), .i_dm_addr(dm_a),
    .i_dm_re(dm_re), .i_dm_we(dm_we), .i_dm_wdata(dm_w), .o_dm_rdata(dm_r), .i_io_addr(io_a),
    .i_io_bit_mask(io_m), .i_io_bit_val(io_val), .i_io_bit_we(io_we));
  // stamp the cycle at which each code address first appears
  always @(posedge clk) begin
    cycn <= cycn + 1;
    if (go && pm_a < 16'h0040 && stamp[pm_a[5:0]] < 0) stamp[pm_a[5:0]] <= cycn;
  end
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 40);
    if (k >= 40) err_count++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // put one instruction word at the next code address
  task automatic p(input bbx_op_t op, input logic [4:0] d, input logic [4:0] s, input logic [15:0] m);
    i_mem.pm[pn] = {op, d, s, m};
    pn++;
  endtask : p
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    i_mem.dm[8'h20] = 8'h5a;
    i_mem.dm[8'h35] = 8'ha7;
    i_mem.dm[8'h41] = 8'h3c;
    i_mem.io[3] = 8'h80;
    p(OP_LDI, 16, 0, 16'h81); p(OP_LSL, 16, 16, 0); p(OP_BR_LO, 0, 0, 1); p(OP_NOP, 0, 0, 0);
    p(OP_BR_SH, 0, 0, 1); p(OP_ROR, 16, 16, 0); p(OP_BR_GE, 0, 0, 1); p(OP_NOP, 0, 0, 0);
    p(OP_ASR, 16, 16, 0); p(OP_ROL, 16, 16, 0); p(OP_LSR, 16, 16, 0); p(OP_BST, 16, 16, 6);
    p(OP_BLD, 17, 17, 0); p(OP_BR_TS, 0, 0, 1); p(OP_NOP, 0, 0, 0); p(OP_IRQ_ON, 0, 0, 0);
    p(OP_BR_ID, 0, 0, 1); p(OP_FLAG_SET, 0, 0, 5); p(OP_BR_HC, 0, 0, 1); p(OP_LDI, 26, 0, 16'h20);
    p(OP_LDI, 27, 0, 0); p(OP_LD, 18, 0, 16'h4); p(OP_ST, 0, 17, 16'h8); p(OP_LDI, 28, 0, 16'h30);
    p(OP_LDI, 29, 0, 0); p(OP_LDD, 19, 0, 5); p(OP_STS, 0, 18, 16'h40); p(OP_LDS, 20, 0, 16'h41);
    p(OP_IO_SET, 0, 0, 16'h83); p(OP_IO_CLR, 0, 0, 16'h1c3); p(OP_MOV, 21, 16, 0);
    p(OP_REG_PAIR_COPY, 22, 26, 0); p(OP_LDI, 30, 0, 16'h8b); p(OP_LDI, 31, 0, 0); p(OP_LPM, 24, 0, 2);
    p(OP_IRQ_OFF, 0, 0, 0); p(OP_FLAG_CLR, 0, 0, 0); p(OP_BR_LT, 0, 0, 1); p(OP_NOP, 0, 0, 0);
    p(OP_BR_VS, 0, 0, 1); p(OP_NOP, 0, 0, 0); p(OP_BR_HS, 0, 0, 1); p(OP_NOP, 0, 0, 0);
    p(OP_BR_MI, 0, 0, 1); p(OP_BR_PL, 0, 0, 1); p(OP_NOP, 0, 0, 0); p(OP_BR_TC, 0, 0, 1);
    p(OP_BR_VC, 0, 0, 1); p(OP_BR_IE, 0, 0, 1); p(OP_STD, 0, 21, 16'h42); p(OP_LDD, 25, 0, 16'h42);
    p(OP_BR_ID, 0, 0, 16'h7f);
    // reset values, read-only and unmapped places
    wb(1'b0, ADR_FLAGS, 32'h0, q); chk("flags", q, {24'h0, RST_FLAGS});
    wb(1'b0, ADR_PC, 32'h0, q); chk("pc", q, {16'h0, RST_PC});
    wb(1'b1, ADR_FLAGS, 32'hff, q); wb(1'b0, ADR_FLAGS, 32'h0, q); chk("flags ro", q, 32'h0);
    wb(1'b1, 8'h20, 32'h5, q); wb(1'b0, 8'h20, 32'h0, q); chk("unmapped", q, 32'h0);
    // run until the closing self-branch is reached
    wb(1'b1, ADR_CTRL, 32'h1, q);
    go <= 1'b1;
    n = 0;
    while (stamp[51] < 0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600) err_count++;
    repeat (4) @(posedge clk);
    wb(1'b0, ADR_FLAGS, 32'h0, q); chk("flags", q, 32'h68);
    wb(1'b0, ADR_PC, 32'h0, q); chk("pc", q, 32'h33);
    wb(1'b1, ADR_CTRL, 32'h0, q);
    repeat (4) @(posedge clk);
    wb(1'b0, ADR_CTRL, 32'h0, q); chk("ctrl", q, 32'h0);
    for (int i = 0; i < 15; i++) begin
      wb(1'b1, ADR_RSEL, rn[i], q);
      wb(1'b0, ADR_RDATA, 32'h0, q);
      chk("register", q, rv[i]);
    end
    chk("dm 20", {24'h0, i_mem.dm[8'h20]}, 32'h01);
    chk("dm 40", {24'h0, i_mem.dm[8'h40]}, 32'h5a);
    chk("dm 8e", {24'h0, i_mem.dm[8'h8e]}, 32'h40);
    chk("io 3", {24'h0, i_mem.io[3]}, 32'h04);
    for (int i = 0; i < 32; i++) chk("cycles", stamp[tt[i]] - stamp[tf[i]], tn[i]);
    for (int i = 0; i < 7; i++) chk("skipped", stamp[sk[i]], 32'hffffffff);
    give_verdict;
  end
endmodule : tb

// >>> include/bbx_pkg.sv
// shared constants and types for the branch, bit and transfer execution core
package bbx_pkg;
  // status flag bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;
  // wishbone register byte offsets
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_FLAGS = 8'h04;
  localparam logic [7:0] ADR_PC    = 8'h08;
  localparam logic [7:0] ADR_RSEL  = 8'h0c;
  localparam logic [7:0] ADR_RDATA = 8'h10;
  // values after reset
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [7:0]  RST_REG   = 8'h00;
  // low register of each pointer pair
  localparam logic [4:0] PTR_X = 5'h1a;
  localparam logic [4:0] PTR_Y = 5'h1c;
  localparam logic [4:0] PTR_Z = 5'h1e;
  // pointer modes in imm[3:2]
  localparam logic [1:0] PM_PLAIN   = 2'h0;
  localparam logic [1:0] PM_POSTINC = 2'h1;
  localparam logic [1:0] PM_PREDEC  = 2'h2;
  // opcodes in instruction bits [31:26]
  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_BR_SH = 6'h01, OP_BR_LO = 6'h02, OP_BR_MI = 6'h03,
    OP_BR_PL = 6'h04, OP_BR_GE = 6'h05, OP_BR_LT = 6'h06, OP_BR_HS = 6'h07,
    OP_BR_HC = 6'h08, OP_BR_TS = 6'h09, OP_BR_TC = 6'h0a, OP_BR_VS = 6'h0b,
    OP_BR_VC = 6'h0c, OP_BR_IE = 6'h0d, OP_BR_ID = 6'h0e, OP_IO_SET = 6'h0f,
    OP_IO_CLR = 6'h10, OP_LSL = 6'h11, OP_LSR = 6'h12, OP_ROL = 6'h13,
    OP_ROR = 6'h14, OP_ASR = 6'h15, OP_FLAG_SET = 6'h16, OP_FLAG_CLR = 6'h17,
    OP_BST = 6'h18, OP_BLD = 6'h19, OP_IRQ_ON = 6'h1a, OP_IRQ_OFF = 6'h1b,
    OP_MOV = 6'h1c, OP_REG_PAIR_COPY = 6'h1d, OP_LDI = 6'h1e, OP_LD = 6'h1f,
    OP_ST = 6'h20, OP_LDD = 6'h21, OP_STD = 6'h22, OP_LDS = 6'h23,
    OP_STS = 6'h24, OP_LPM = 6'h25
  } bbx_op_t;
  // execution cycle state
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00, CS_E1 = 2'b01, CS_E2 = 2'b10, CS_E3 = 2'b11
  } bbx_state_t;
endpackage : bbx_pkg
